// file: dv/adcs_conv_model.sv
// behavioural analog conversion machine answering each start late
`timescale 1ns/1ps
module adcs_conv_model #(
   parameter int DLY = 3
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // requests from the sequencer
   input  wire adcs_pkg::adcs_conv_t req,
   // answers to the sequencer
   output logic                      done,
   output logic      [9:0]           data
);
   int         cnt;
   logic [2:0] chan_q;
   // one conversion at a time, data toggles outside the done cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt    <= 0;
         chan_q <= 3'h0;
         done   <= 1'b0;
         data   <= 10'h155;
      end else begin
         done <= 1'b0;
         data <= ~data;
         if (req.go) begin
            cnt    <= DLY;
            chan_q <= req.chan;
         end else if (cnt > 1) begin
            cnt <= cnt - 1;
         end else if (cnt == 1) begin
            cnt  <= 0;
            done <= 1'b1;
            data <= {7'h2D, chan_q}; // result tells the channel apart
         end
      end
   end
endmodule // adcs_conv_model

// file: dv/test_adc_sequence_controller.sv
// self-checking bench of the adc sequence controller
`timescale 1ns/1ps
`include "adcs_consts.svh"
module test_adc_sequence_controller;
   logic                 CLK_SYS, RSTN, AVS_READ, AVS_WRITE, DEBUG_MODE;
   logic [5:0]           AVS_ADDRESS;
   logic [31:0]          AVS_WRITEDATA, AVS_READDATA, q;
   logic                 AVS_WAITREQUEST, SAMPLE_PHASE, CONV_FREEZE;
   logic                 ADC_TICK, CONV_DONE, SEQ_IRQ, tick_d;
   logic [9:0]           CONV_DATA;
   adcs_pkg::adcs_conv_t CONV_REQ;
   int                   n_errors, n_checks, n_tick, n_all, n_go;
   adcs_ctrl dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_BYTEENABLE(4'hF),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .CONV_REQ(CONV_REQ),
      .SAMPLE_PHASE(SAMPLE_PHASE), .CONV_FREEZE(CONV_FREEZE),
      .ADC_TICK(ADC_TICK), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA),
      .DEBUG_MODE(DEBUG_MODE), .SEQ_IRQ(SEQ_IRQ));
   adcs_conv_model model (.clk(CLK_SYS), .rstn(RSTN), .req(CONV_REQ),
      .done(CONV_DONE), .data(CONV_DATA));
   // clock and time-zero values
   initial begin
      CLK_SYS = 1'b0;
      RSTN = 1'b0;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_ADDRESS = 6'h00;
      AVS_WRITEDATA = 32'h0;
      DEBUG_MODE = 1'b0;
      forever #4 CLK_SYS = ~CLK_SYS;
   end
   // count converter ticks and conversion starts
   always @(posedge CLK_SYS) begin
      if (ADC_TICK === 1'b1) n_all++;
      // sample phase output lags the state, pair it with last tick
      if (SAMPLE_PHASE === 1'b1 && tick_d === 1'b1) n_tick++;
      tick_d = ADC_TICK;
      if (CONV_REQ.go === 1'b1) n_go++;
   end
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge CLK_SYS);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      // waitrequest and read data as they stood at each rising edge
      do begin
         @(posedge CLK_SYS);
      end while (AVS_WAITREQUEST !== 1'b0);
      r = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask
   // poll status until the sequence done flag shows
   task automatic wait_done();
      int i;
      for (i = 0; i < 500; i++) begin
         rd(`ADCS_OFF_STAT, q);
         if (q[`ADCS_ST_SCF] === 1'b1) break;
      end
      if (i == 500) n_errors++;
   endtask
   task automatic t_tick(input int p);
      @(negedge CLK_SYS);
      n_all = 0;
      repeat (40) @(negedge CLK_SYS);
      check(32'(n_all), 32'(40 / (2 * (p + 1))));
   endtask
   task automatic t_reset();
      rd(`ADCS_OFF_CTL4, q);
      check(q, 32'h01);
      t_tick(1);
      rd(`ADCS_OFF_STAT, q);
      check(q, 32'h0);
      wr(6'h18, 32'hFF);
      rd(6'h18, q);
      check(q, 32'h0);
      wr(`ADCS_OFF_CTL4, 32'h03); // prescale kept below 8
      t_tick(3);
   endtask
   task automatic t_seq();
      wr(`ADCS_OFF_CTL4, 32'h80); // prescale kept below 8
      wr(`ADCS_OFF_CTL5, 32'h16);
      wait_done();
      check(q, 32'h0000800F);
      check({26'h0, CONV_REQ}, 32'h16);
      for (int i = 0; i < 4; i++) begin
         rd(6'h20 + 6'(4 * i), q);
         check(q, {16'h0, 7'h2D, 3'(6 + i), 6'h0});
      end
      wr(`ADCS_OFF_CTL4, 32'h00);
      wait_done();
      rd(6'h20, q);
      check(q, 32'h00005B00);
      check({26'h0, CONV_REQ}, 32'h06);
   endtask
   // irq flag, both flag-clear modes, test-bit pointer clear
   task automatic t_flags();
      wr(`ADCS_OFF_CTL2, 32'h01);
      wr(`ADCS_OFF_CTL3, 32'h08);
      wr(`ADCS_OFF_CTL5, 32'h16);
      wait_done();
      check(32'(SEQ_IRQ), 32'h1);
      rd(6'h20, q);
      rd(`ADCS_OFF_STAT, q);
      check(q, 32'h00008000);
      check(32'(SEQ_IRQ), 32'h0);
      wr(`ADCS_OFF_CTL2, 32'h02);
      wr(`ADCS_OFF_CTL5, 32'h16);
      wait_done();
      rd(6'h20, q);
      rd(`ADCS_OFF_STAT, q);
      check(q, 32'h0);
      wr(`ADCS_OFF_CTL2, 32'h00);
      wr(`ADCS_OFF_CTL3, 32'h0C);
      wr(`ADCS_OFF_CTL5, 32'h16);
      wait_done();
      check(32'(q[10:8]), 32'h1);
      wr(`ADCS_OFF_TEST, 32'h01);
      wr(`ADCS_OFF_TEST, 32'h00);
      rd(`ADCS_OFF_STAT, q);
      check(32'(q[10:8]), 32'h0);
   endtask
   task automatic t_smp();
      wr(`ADCS_OFF_CTL3, 32'h08);
      for (int k = 0; k < 4; k++) begin
         @(negedge CLK_SYS);
         n_tick = 0;
         wr(`ADCS_OFF_CTL4, {24'h0, 1'b1, 2'(k), 5'h0});
         wait_done();
         check(32'(n_tick), 32'(2 << k));
         check(32'(q[7:0]), 32'h01);
      end
   endtask
   task automatic t_fifo();
      wr(`ADCS_OFF_CTL3, 32'h0C);
      for (int k = 1; k < 3; k++) begin
         wr(`ADCS_OFF_CTL5, 32'h16);
         wait_done();
         check(32'(q[10:8]), 32'(k));
      end
      wr(`ADCS_OFF_CTL3, 32'h04);
      wr(`ADCS_OFF_CTL5, 32'h56);
      wait_done();
      check(32'(q[10:8]), 32'h2);
   endtask
   task automatic t_abort();
      wr(`ADCS_OFF_CTL3, 32'h00);
      wr(`ADCS_OFF_CTL5, 32'h56);
      q = 32'h0;
      for (int i = 0; i < 200 && q[10:8] < 3'h3; i++) rd(`ADCS_OFF_STAT, q);
      wr(`ADCS_OFF_CTL4, 32'h80);
      rd(`ADCS_OFF_STAT, q);
      check(q, 32'h0);
      wait_done();
      check(q, 32'h000080FF);
   endtask
   task automatic t_scan();
      wr(`ADCS_OFF_CTL5, 32'h36);
      wait_done();
      @(negedge CLK_SYS);
      n_go = 0;
      repeat (100) @(negedge CLK_SYS);
      check(32'(n_go > 0), 32'h1);
      wr(`ADCS_OFF_CTL5, 32'h16);
      wait_done();
      check(q, 32'h0000800F);
   endtask
   task automatic t_freeze();
      for (int k = 0; k < 4; k++) begin
         wr(`ADCS_OFF_CTL3, 32'(k));
         wr(`ADCS_OFF_CTL5, 32'h16);
         DEBUG_MODE <= 1'b1;
         repeat (100) @(negedge CLK_SYS);
         check(32'(CONV_FREEZE), 32'(k >> 1));
         @(posedge CLK_SYS);
         DEBUG_MODE <= 1'b0;
         wait_done();
         check(q, 32'h0000800F);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (60000) @(posedge CLK_SYS);
      n_errors++;
      end_of_test();
   end
   // main sequence
   initial begin
      repeat (8) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      t_reset();
      t_seq();
      t_smp();
      t_fifo();
      t_abort();
      t_scan();
      t_flags();
      t_freeze();
      end_of_test();
   end
endmodule // test_adc_sequence_controller

// file: hdl/adcs_consts.svh
// register map, field positions and reset values of the adc sequencer
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH
// byte offsets on the register bus
`define ADCS_OFF_CTL3      6'h00
`define ADCS_OFF_CTL4      6'h04
`define ADCS_OFF_CTL5      6'h08
`define ADCS_OFF_CTL2      6'h0C
`define ADCS_OFF_STAT      6'h10
`define ADCS_OFF_TEST      6'h14
`define ADCS_RES_BIT       5
// control three fields
`define ADCS_C3_SHORT      3
`define ADCS_C3_FIFO       2
`define ADCS_C3_FRZ_HI     1
`define ADCS_C3_FRZ_LO     0
// control four fields
`define ADCS_C4_RESOLUTION_SEL      7
`define ADCS_C4_SMP_HI     6
`define ADCS_C4_SMP_LO     5
`define ADCS_C4_PRS_HI     4
`define ADCS_C4_PRS_LO     0
// control five fields
`define ADCS_C5_LONG       6
`define ADCS_C5_SCAN       5
`define ADCS_C5_MULTI_CHANNEL_SEL       4
`define ADCS_C5_SPECIAL    3
`define ADCS_C5_CHAN_HI    2
// control two fields
`define ADCS_C2_FAST_FLAG_CLEAR       1
`define ADCS_C2_IRQEN      0
// status fields
`define ADCS_ST_IRQF       16
`define ADCS_ST_SCF        15
`define ADCS_ST_CNT_LO     8
// reset values
`define ADCS_RST_CTL3      4'h0
`define ADCS_RST_CTL4      8'h01
`define ADCS_RST_CTL5      8'h00
`define ADCS_RST_CTL2      2'h0
// sequencing constants
`define ADCS_SMP_BASE      5'h02
`define ADCS_LEN_LONG      4'h8
`define ADCS_LEN_SHORT     4'h1
`define ADCS_LEN_NORM      4'h4
`define ADCS_FRZ_FINISH    2'h2
`define ADCS_FRZ_HOLD      2'h3
`endif

// file: hdl/adcs_ctrl.sv
// adc sequence controller with avalon-mm register slave
//
// Behaviour
// - ordering bit zero maps results by position
// - fifo ordering keeps pointer across sequences
// - pointer wraps from last to first register
// - pointer cleared on reset, test bit, non-fifo ends
// - status shows pointer as conversion counter
// - per-register done flags show valid results
// - freeze field selects debug response
// - leaving debug resumes without restart
// - control four/five write aborts sequence
// - control four/five write starts, clears flags
// - resolution bit picks 8 or 10 bits
// - sample bits give 2,4,8,16 converter clocks
// - bus clock divided by prescale+1, then 2
// - prescale field resets to one
// - length bits give 4, 1 or 8
// - non-fifo uses registers from zero upward
// - single mode runs once, flags, idles
// - continuous mode flags and restarts immediately
// - fast clear or status-then-result clears flag
// - sequence irq flag pends until serviced
// - multi-channel increments wrapping channel code
`timescale 1ns/1ps
`include "adcs_consts.svh"

module adcs_ctrl #(
   parameter int NRES = 8,
   parameter int DW   = 10
) (
   // clock and reset
   input  wire logic                CLK_SYS,
   input  wire logic                RSTN,
   // avalon-mm slave
   input  wire logic [5:0]          AVS_ADDRESS,
   input  wire logic                AVS_READ,
   input  wire logic                AVS_WRITE,
   input  wire logic [31:0]         AVS_WRITEDATA,
   input  wire logic [3:0]          AVS_BYTEENABLE,
   output logic      [31:0]         AVS_READDATA,
   output logic                     AVS_WAITREQUEST,
   // analog conversion machine
   output adcs_pkg::adcs_conv_t     CONV_REQ,
   output logic                     SAMPLE_PHASE,
   output logic                     CONV_FREEZE,
   output logic                     ADC_TICK,
   input  wire logic                CONV_DONE,
   input  wire logic [DW-1:0]       CONV_DATA,
   // debug pin and interrupt
   input  wire logic                DEBUG_MODE,
   output logic                     SEQ_IRQ
);

   localparam int PW = $clog2(NRES);

   // elaboration check: eight results, ten-bit data
   if (NRES != 8 || DW != 10) begin : g_bad_param
      $error("adcs_ctrl supports NRES=8 and DW=10 only");
   end

   //------------------------------------------------------------
   // declarations
   //------------------------------------------------------------
   logic [3:0]          ctl3_q;
   logic [7:0]          ctl4_q;
   logic [7:0]          ctl5_q;
   logic [1:0]          ctl2_q;
   logic                test_q;
   logic                ack_q;
   logic                acc;
   logic                wr_en;
   logic                start;
   logic [31:0]         rd_d;
   logic                dbg_m_q;
   logic                dbg_q;
   logic [4:0]          pre_cnt_q;
   logic                half_q;
   logic                adc_tick;
   logic                pre_tick;
   adcs_pkg::adcs_state_t st_q;
   logic [4:0]          smp_cnt_q;
   logic [4:0]          smp_len;
   logic [3:0]          seq_len;
   logic [2:0]          seq_idx_q;
   logic [PW-1:0]       ptr_q;
   logic [2:0]          chan_q;
   logic                hold;
   logic                store;
   logic                last;
   logic [15:0]         res_q [NRES];
   logic [15:0]         res_fmt;
   logic [NRES-1:0]     ccf_q;
   logic [NRES-1:0]     armed_q;
   logic [NRES-1:0]     ccf_clr;
   logic                res_hit;
   logic [PW-1:0]       res_idx;
   logic                scf_q;
   logic                irqf_q;
   logic [1:0]          frz;
   logic                fifo;

   //------------------------------------------------------------
   // avalon slave: one wait state, effects on the accepting edge
   //------------------------------------------------------------
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
   assign acc     = (AVS_READ | AVS_WRITE) & ack_q;
   assign wr_en   = acc & AVS_WRITE & AVS_BYTEENABLE[0];
   assign res_hit = acc & AVS_ADDRESS[`ADCS_RES_BIT];
   assign res_idx = AVS_ADDRESS[PW+1:2];
   assign start   = wr_en & ((AVS_ADDRESS == `ADCS_OFF_CTL4) |
                             (AVS_ADDRESS == `ADCS_OFF_CTL5));

   // acknowledge toggles once per request
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
      end
   end

   // read multiplexer, sampled in the wait cycle
   always_comb begin
      rd_d = 32'h0000_0000;
      if (AVS_ADDRESS[`ADCS_RES_BIT]) begin
         rd_d[15:0] = res_q[res_idx];
      end else begin
         case (AVS_ADDRESS)
            `ADCS_OFF_CTL3: rd_d[3:0] = ctl3_q;
            `ADCS_OFF_CTL4: rd_d[7:0] = ctl4_q;
            `ADCS_OFF_CTL5: rd_d[7:0] = ctl5_q;
            `ADCS_OFF_CTL2: rd_d[1:0] = ctl2_q;
            `ADCS_OFF_TEST: rd_d[0]   = test_q;
            `ADCS_OFF_STAT: begin
               rd_d[NRES-1:0]                  = ccf_q;
               rd_d[`ADCS_ST_CNT_LO+:PW]       = ptr_q;
               rd_d[`ADCS_ST_SCF]              = scf_q;
               rd_d[`ADCS_ST_IRQF]             = irqf_q;
            end
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   // read data register
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ & ~ack_q) begin
         AVS_READDATA <= rd_d;
      end
   end

   //------------------------------------------------------------
   // control registers
   //------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ctl3_q <= `ADCS_RST_CTL3;
         ctl4_q <= `ADCS_RST_CTL4;
         ctl5_q <= `ADCS_RST_CTL5;
         ctl2_q <= `ADCS_RST_CTL2;
         test_q <= 1'b0;
      end else if (wr_en) begin
         case (AVS_ADDRESS)
            `ADCS_OFF_CTL3: ctl3_q <= AVS_WRITEDATA[3:0];
            `ADCS_OFF_CTL4: ctl4_q <= AVS_WRITEDATA[7:0];
            `ADCS_OFF_CTL5: ctl5_q <= AVS_WRITEDATA[7:0];
            `ADCS_OFF_CTL2: ctl2_q <= AVS_WRITEDATA[1:0];
            `ADCS_OFF_TEST: test_q <= AVS_WRITEDATA[0];
            default: ;
         endcase
      end
   end

   assign frz  = ctl3_q[`ADCS_C3_FRZ_HI:`ADCS_C3_FRZ_LO];
   assign fifo = ctl3_q[`ADCS_C3_FIFO];

   //------------------------------------------------------------
   // debug pin synchroniser
   //------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         dbg_m_q <= 1'b0;
         dbg_q   <= 1'b0;
      end else begin
         dbg_m_q <= DEBUG_MODE;
         dbg_q   <= dbg_m_q;
      end
   end

   // freeze: 00 and 01 run on, 10 at a conversion boundary, 11 at once
   assign hold = dbg_q & ((frz == `ADCS_FRZ_HOLD) |
                 ((frz == `ADCS_FRZ_FINISH) & (st_q == adcs_pkg::ST_SAMPLE)
                  & (smp_cnt_q == 5'h00)));
   assign CONV_FREEZE = hold;

   //------------------------------------------------------------
   // prescaler: modulus counter then divide by two, as enables
   //------------------------------------------------------------
   assign pre_tick = (pre_cnt_q == ctl4_q[`ADCS_C4_PRS_HI:`ADCS_C4_PRS_LO]);
   assign adc_tick = pre_tick & half_q & ~hold;
   assign ADC_TICK = adc_tick;

   // counter stops while frozen so the phase resumes unchanged
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         pre_cnt_q <= 5'h00;
         half_q    <= 1'b0;
      end else if (!hold) begin
         pre_cnt_q <= pre_tick ? 5'h00 : pre_cnt_q + 5'h01;
         if (pre_tick) begin
            half_q <= ~half_q;
         end
      end
   end

   //------------------------------------------------------------
   // sequence parameters
   //------------------------------------------------------------
   assign smp_len = `ADCS_SMP_BASE <<
                    ctl4_q[`ADCS_C4_SMP_HI:`ADCS_C4_SMP_LO];
   assign seq_len = ctl5_q[`ADCS_C5_LONG]  ? `ADCS_LEN_LONG :
                    ctl3_q[`ADCS_C3_SHORT] ? `ADCS_LEN_SHORT :
                    `ADCS_LEN_NORM;
   assign store   = (st_q == adcs_pkg::ST_CONVERT) & CONV_DONE & ~start;
   assign last    = ({1'b0, seq_idx_q} == seq_len - 4'h1);

   // result format: left justified, 8-bit keeps the upper bits
   assign res_fmt = ctl4_q[`ADCS_C4_RESOLUTION_SEL] ? {CONV_DATA, 6'h00} :
                    {CONV_DATA[DW-1:DW-8], 8'h00};

   //------------------------------------------------------------
   // sequencer state
   //------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_q      <= adcs_pkg::ST_IDLE;
         smp_cnt_q <= 5'h00;
         seq_idx_q <= 3'h0;
         chan_q    <= 3'h0;
      end else if (test_q) begin
         st_q      <= adcs_pkg::ST_IDLE;
         smp_cnt_q <= 5'h00;
         seq_idx_q <= 3'h0;
      end else if (start) begin
         st_q      <= adcs_pkg::ST_SAMPLE;
         smp_cnt_q <= 5'h00;
         seq_idx_q <= 3'h0;
         chan_q    <= AVS_ADDRESS == `ADCS_OFF_CTL5 ?
                      AVS_WRITEDATA[`ADCS_C5_CHAN_HI:0] :
                      ctl5_q[`ADCS_C5_CHAN_HI:0];
      end else begin
         case (st_q)
            adcs_pkg::ST_SAMPLE: begin
               if (adc_tick) begin
                  if (smp_cnt_q == smp_len - 5'h01) begin
                     st_q      <= adcs_pkg::ST_CONVERT;
                     smp_cnt_q <= 5'h00;
                  end else begin
                     smp_cnt_q <= smp_cnt_q + 5'h01;
                  end
               end
            end
            adcs_pkg::ST_CONVERT: begin
               if (CONV_DONE) begin
                  if (ctl5_q[`ADCS_C5_MULTI_CHANNEL_SEL]) begin
                     chan_q <= chan_q + 3'h1;
                  end
                  if (!last) begin
                     seq_idx_q <= seq_idx_q + 3'h1;
                     st_q      <= adcs_pkg::ST_SAMPLE;
                  end else begin
                     seq_idx_q <= 3'h0;
                     chan_q    <= ctl5_q[`ADCS_C5_CHAN_HI:0];
                     st_q      <= ctl5_q[`ADCS_C5_SCAN] ?
                                  adcs_pkg::ST_SAMPLE :
                                  adcs_pkg::ST_IDLE;
                  end
               end
            end
            adcs_pkg::ST_IDLE: ;
            default: st_q <= adcs_pkg::ST_IDLE;
         endcase
      end
   end

   // result pointer: cleared on non-fifo start and end, wraps in fifo
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ptr_q <= '0;
      end else if (test_q) begin
         ptr_q <= '0;
      end else if (start && !fifo) begin
         ptr_q <= '0;
      end else if (store) begin
         if (last && !fifo) begin
            ptr_q <= '0;
         end else begin
            ptr_q <= ptr_q + PW'(1);
         end
      end
   end

   // result storage indexed by the pointer
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         for (int i = 0; i < NRES; i++) begin
            res_q[i] <= 16'h0000;
         end
      end else if (store) begin
         res_q[ptr_q] <= res_fmt;
      end
   end

   //------------------------------------------------------------
   // flags: conversion done, sequence done, interrupt
   //------------------------------------------------------------
   always_comb begin
      ccf_clr = '0;
      if (res_hit && (ctl2_q[`ADCS_C2_FAST_FLAG_CLEAR] ||
                      (AVS_READ && armed_q[res_idx]))) begin
         ccf_clr[res_idx] = ccf_q[res_idx];
      end
   end

   // set wins over clear; start clears all
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         ccf_q   <= '0;
         armed_q <= '0;
      end else if (start) begin
         ccf_q   <= '0;
         armed_q <= '0;
      end else begin
         ccf_q   <= (ccf_q & ~ccf_clr) |
                    (store ? NRES'(1) << ptr_q : '0);
         armed_q <= (armed_q & ~ccf_clr) |
                    (acc && AVS_READ &&
                     AVS_ADDRESS == `ADCS_OFF_STAT ? ccf_q : '0);
      end
   end

   // sequence done and its interrupt request
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         scf_q  <= 1'b0;
         irqf_q <= 1'b0;
      end else if (start) begin
         scf_q  <= 1'b0;
         irqf_q <= 1'b0;
      end else if (store && last) begin
         scf_q  <= 1'b1;
         irqf_q <= irqf_q | ctl2_q[`ADCS_C2_IRQEN];
      end else begin
         if (res_hit && AVS_READ && ctl2_q[`ADCS_C2_FAST_FLAG_CLEAR]) begin
            scf_q <= 1'b0;
         end
         if (|ccf_clr) begin
            irqf_q <= 1'b0;
         end
      end
   end

   assign SEQ_IRQ = irqf_q;

   //------------------------------------------------------------
   // conversion request to the analog machine
   //------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         CONV_REQ     <= '0;
         SAMPLE_PHASE <= 1'b0;
      end else begin
         CONV_REQ.go      <= (st_q == adcs_pkg::ST_SAMPLE) & adc_tick &
                             (smp_cnt_q == smp_len - 5'h01) & ~start &
                             ~test_q;
         CONV_REQ.resolution_sel   <= ctl4_q[`ADCS_C4_RESOLUTION_SEL];
         CONV_REQ.special <= ctl5_q[`ADCS_C5_SPECIAL];
         CONV_REQ.chan    <= chan_q;
         SAMPLE_PHASE     <= (st_q == adcs_pkg::ST_SAMPLE);
      end
   end

   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   a_start_clears: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      start && !test_q |=> ccf_q == '0 && !scf_q
      && st_q == adcs_pkg::ST_SAMPLE)
      else $error("start did not clear flags");

   a_fifo_keeps_ptr: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      start && fifo && !test_q |=> ptr_q == $past(ptr_q))
      else $error("fifo start moved pointer");

   a_ptr_wraps: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      store && fifo && !test_q && ptr_q == PW'(NRES - 1)
      |=> ptr_q == '0)
      else $error("pointer did not wrap");

   a_ptr_clear: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      (start && !fifo) || test_q |=> ptr_q == '0)
      else $error("pointer not cleared");

   a_result_map: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      store && !test_q |=> res_q[$past(ptr_q)] == $past(res_fmt)
      && ccf_q[$past(ptr_q)])
      else $error("result not stored at pointer");

   a_status_count: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      AVS_READ && !ack_q && AVS_ADDRESS == `ADCS_OFF_STAT
      |=> AVS_READDATA[`ADCS_ST_CNT_LO+:PW] == $past(ptr_q))
      else $error("status counter wrong");

   a_freeze_hold: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      hold && st_q == adcs_pkg::ST_SAMPLE && !start && !test_q
      |=> $stable(smp_cnt_q) && $stable(pre_cnt_q))
      else $error("frozen sequencer advanced");

   a_single_idle: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      store && last && !ctl5_q[`ADCS_C5_SCAN] && !test_q
      |=> st_q == adcs_pkg::ST_IDLE && scf_q)
      else $error("single sequence did not idle");

   a_scan_restart: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      store && last && ctl5_q[`ADCS_C5_SCAN] && !test_q
      |=> st_q == adcs_pkg::ST_SAMPLE && seq_idx_q == 3'h0)
      else $error("scan did not restart");

   a_sample_len: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      st_q == adcs_pkg::ST_SAMPLE && adc_tick && !start && !test_q
      && smp_cnt_q == smp_len - 5'h01
      |=> st_q == adcs_pkg::ST_CONVERT ##0 CONV_REQ.go)
      else $error("final sample length wrong");

   a_irq_pends: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      irqf_q && !start && ccf_clr == '0 |=> irqf_q)
      else $error("irq flag dropped early");

   a_prescale_wrap: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      pre_tick && !hold |=> pre_cnt_q == 5'h00
      && half_q != $past(half_q))
      else $error("prescaler modulus wrong");

endmodule // adcs_ctrl

// file: hdl/adcs_pkg.sv
// types shared by the adc sequencer
package adcs_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT
   } adcs_state_t;

   // request to the analog sample-and-hold and conversion machine
   typedef struct packed {
      logic       go;       // one-cycle start of a conversion
      logic       resolution_sel;    // 1: 10-bit, 0: 8-bit conversion
      logic       special;  // special channel conversion
      logic [2:0] chan;     // channel code
   } adcs_conv_t;
endpackage
